// ===== hdl/aur_receiver.sv
// asynchronous serial receiver with 9-bit address detect
// assumes a one-cycle read/write strobe register port, one clock
// Function
// - recovery stage oversamples line at 16x
// - shift register steps once per bit
// - receive pin drives the recovery stage
// - bit rate from divisor and select bits
// - runs when port enabled, sync clear
// - nine-bit characters when ninth enable set
// - accept characters only while continuous enable
// - completion sets flag; request needs enable
// - status shows ninth bit and errors
// - data read returns low eight bits
// - clearing continuous enable clears errors
// - address detect active in nine-bit mode
// - detect off: every character loaded, flagged
// - priority bit selects interrupt level
// - request needs global and peripheral enables
// - start, eight/nine data, one stop
// - least significant bit first
// - generator runs at 16x or 64x
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module aur_receiver (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       serialInPin,
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	output logic            irqHigh,
	output logic            irqLow
);
	import aur_pkg::*;

	typedef enum logic [1:0] {IDLE, START, DATA, STOP} aur_state_t;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] rxCtl_q;
	logic [7:0] txCtl_q;
	logic [7:0] baudCtl_q;
	logic [7:0] divHigh_q;
	logic [7:0] divLow_q;
	logic [7:0] irqCtl_q;
	logic       rxIe_q;
	logic       rxPrio_q;
	logic       frameErr_q;
	logic       overrun_q;
	logic       full_q;
	logic [8:0] buf_q;
	logic [8:0] shift_q;
	logic [3:0] bitCnt_q;
	aur_state_t state_q;

	logic       run;
	logic       tick;
	logic       startSeen;
	logic       bitStrobe;
	logic       bitValue;
	logic       ninthMode;
	logic [3:0] lastBit;
	logic       charDone;
	logic       keep;
	logic [8:0] charWord;
	logic       dataRead;
	logic       frameEnd;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign run = rxCtl_q[B_PORT_EN] && !txCtl_q[B_SYNC_SEL]
		&& rxCtl_q[B_CONT_EN];
	assign ninthMode = rxCtl_q[B_NINTH_EN];
	assign lastBit = ninthMode ? 4'h8 : 4'h7;
	assign dataRead = regRd && regAddr == OFF_RX_DATA;
	// the recovery stage is dropped for one cycle at the end of each frame;
	// otherwise it free-runs and never rearms for the next start edge
	assign frameEnd = bitStrobe && (state_q == STOP
		|| (state_q == START && bitValue));

	aur_baud_gen #(
		.DIV_W(16)
	) u_baud (
		.clock    (clock),
		.rst      (rst),
		.run      (run),
		.divisor  ({divHigh_q, divLow_q}),
		.highSpeed(txCtl_q[B_HIGH_SPD]),
		.wideDiv  (baudCtl_q[B_WIDE_DIV]),
		.tick     (tick)
	);

	aur_recovery u_recovery (
		.clock    (clock),
		.rst      (rst),
		.run      (run && !frameEnd),
		.tick     (tick),
		.lineIn   (serialInPin),
		.startSeen(startSeen),
		.bitStrobe(bitStrobe),
		.bitValue (bitValue)
	);

	// ----------------------------------------------------------------
	// character framing
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q  <= IDLE;
			bitCnt_q <= '0;
		end else if (!run) begin
			state_q  <= IDLE;
			bitCnt_q <= '0;
		end else begin
			unique case (state_q)
				IDLE: begin
					if (startSeen) begin
						state_q <= START;
					end
				end
				START: begin
					if (bitStrobe) begin
						// a high start sample is a glitch, not a character
						state_q  <= bitValue ? IDLE : DATA;
						bitCnt_q <= '0;
					end
				end
				DATA: begin
					if (bitStrobe) begin
						bitCnt_q <= bitCnt_q + 1'b1;
						if (bitCnt_q == lastBit) begin
							state_q <= STOP;
						end
					end
				end
				STOP: begin
					if (bitStrobe) begin
						state_q <= IDLE;
					end
				end
			endcase
		end
	end

	// shifts once per recovered bit, not on the 16x tick
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
		end else if (state_q == DATA && bitStrobe) begin
			shift_q <= {bitValue, shift_q[8:1]};
		end
	end

	assign charDone = run && state_q == STOP && bitStrobe;
	assign charWord = ninthMode ? shift_q : {1'b0, shift_q[8:1]};
	// address detect only counts in nine-bit mode
	assign keep = !(ninthMode && rxCtl_q[B_ADDR_EN])
		|| charWord[8];

	// ----------------------------------------------------------------
	// receive buffer and flags
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buf_q  <= '0;
			full_q <= 1'b0;
		end else if (charDone && keep && !full_q) begin
			buf_q  <= charWord;
			full_q <= 1'b1;
		end else if (dataRead) begin
			full_q <= 1'b0;
		end
	end

	// a new character arriving as the buffer is read still counts as full
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			frameErr_q <= 1'b0;
			overrun_q  <= 1'b0;
		end else if (!rxCtl_q[B_CONT_EN]) begin
			frameErr_q <= 1'b0;
			overrun_q  <= 1'b0;
		end else if (charDone && keep) begin
			if (!full_q) begin
				frameErr_q <= !bitValue;
			end else begin
				overrun_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxCtl_q   <= RST_REG;
			txCtl_q   <= RST_REG;
			baudCtl_q <= RST_REG;
			divHigh_q <= RST_REG;
			divLow_q  <= RST_REG;
			irqCtl_q  <= RST_REG;
			rxIe_q    <= 1'b0;
			rxPrio_q  <= 1'b0;
		end else if (regWr) begin
			unique case (regAddr)
				OFF_RX_STATUS: rxCtl_q   <= regWrData;
				OFF_TX_STATUS: txCtl_q   <= regWrData;
				OFF_BAUD_CTL:  baudCtl_q <= regWrData;
				OFF_DIV_HIGH:  divHigh_q <= regWrData;
				OFF_DIV_LOW:   divLow_q  <= regWrData;
				OFF_IRQ_CTL:   irqCtl_q  <= regWrData;
				OFF_IRQ_FLAG: begin
					rxIe_q   <= regWrData[B_RX_IE];
					rxPrio_q <= regWrData[B_RX_PRIO];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port, data in the cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdData <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				OFF_RX_STATUS: regRdData <= {rxCtl_q[7:3], frameErr_q,
					overrun_q, buf_q[8] & ninthMode};
				OFF_RX_DATA:   regRdData <= buf_q[7:0];
				OFF_TX_STATUS: regRdData <= txCtl_q;
				OFF_BAUD_CTL:  regRdData <= baudCtl_q;
				OFF_DIV_HIGH:  regRdData <= divHigh_q;
				OFF_DIV_LOW:   regRdData <= divLow_q;
				OFF_IRQ_CTL:   regRdData <= irqCtl_q;
				OFF_IRQ_FLAG:  regRdData <= {5'h00, rxPrio_q, rxIe_q, full_q};
				default:       regRdData <= '0;
			endcase
		end else begin
			regRdData <= '0;
		end
	end

	// ----------------------------------------------------------------
	// interrupt request, level split by priority
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irqHigh <= 1'b0;
			irqLow  <= 1'b0;
		end else begin
			irqHigh <= full_q && rxIe_q && irqCtl_q[B_GLOBAL_IE]
				&& irqCtl_q[B_PERIPH_IE] && rxPrio_q;
			irqLow  <= full_q && rxIe_q && irqCtl_q[B_GLOBAL_IE]
				&& irqCtl_q[B_PERIPH_IE] && !rxPrio_q;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_charKept;
		charDone && keep && !full_q;
	endsequence

	chk_flag_on_char: assert property (@(posedge clock) disable iff (rst)
		s_charKept |=> full_q)
		else $error("receive flag not set after character");
	chk_addr_discard: assert property (@(posedge clock) disable iff (rst)
		(charDone && ninthMode && rxCtl_q[B_ADDR_EN] && !charWord[8]
		&& !full_q) |=> !full_q)
		else $error("data character kept during address detect");
	chk_read_clears: assert property (@(posedge clock) disable iff (rst)
		(dataRead && !charDone) |=> !full_q)
		else $error("flag not cleared by data read");
	chk_err_clear: assert property (@(posedge clock) disable iff (rst)
		!rxCtl_q[B_CONT_EN] |=> !frameErr_q && !overrun_q)
		else $error("errors survive continuous enable clear");
	chk_overrun_set: assert property (@(posedge clock) disable iff (rst)
		(charDone && keep && full_q && rxCtl_q[B_CONT_EN]) |=> overrun_q)
		else $error("overrun not flagged");
	chk_irq_gate: assert property (@(posedge clock) disable iff (rst)
		(irqHigh || irqLow) |-> $past(irqCtl_q[B_GLOBAL_IE] && rxIe_q))
		else $error("interrupt without enables");
	chk_idle_no_run: assert property (@(posedge clock) disable iff (rst)
		!run |=> state_q == IDLE)
		else $error("receiver active while disabled");
	chk_read_data: assert property (@(posedge clock) disable iff (rst)
		dataRead |=> regRdData == $past(buf_q[7:0]))
		else $error("data read returned wrong byte");

	// framer and data path
	sequence s_lastData;
		run && state_q == DATA && bitStrobe && bitCnt_q == lastBit;
	endsequence

	sequence s_statusRead;
		regRd && regAddr == OFF_RX_STATUS;
	endsequence

	chk_frame_err: assert property (@(posedge clock) disable iff (rst)
		s_charKept |=> frameErr_q == $past(!bitValue))
		else $error("framing error does not follow stop sample");
	chk_stop_after: assert property (@(posedge clock) disable iff (rst)
		s_lastData |=> state_q == STOP)
		else $error("stop bit not expected after last data bit");
	chk_frame_end: assert property (@(posedge clock) disable iff (rst)
		frameEnd |=> state_q == IDLE)
		else $error("framer did not return to idle");
	chk_shift_lsb: assert property (@(posedge clock) disable iff (rst)
		(state_q == DATA && bitStrobe) |=> shift_q[8] == $past(bitValue))
		else $error("recovered bit not shifted in at the top");
	chk_buf_hold: assert property (@(posedge clock) disable iff (rst)
		(full_q && !dataRead) |=> full_q && $stable(buf_q))
		else $error("unread character lost or overwritten");

	// register port and requests
	chk_status_bits: assert property (@(posedge clock) disable iff (rst)
		s_statusRead |=> regRdData[B_FRAME_ERR] == $past(frameErr_q)
		&& regRdData[B_OVERRUN] == $past(overrun_q)
		&& regRdData[B_NINTH_BIT] == $past(buf_q[8] && ninthMode))
		else $error("status read lost error or ninth bit");
	chk_irq_high: assert property (@(posedge clock) disable iff (rst)
		irqHigh |-> !irqLow && $past(rxPrio_q))
		else $error("high request without high priority");
	chk_irq_low: assert property (@(posedge clock) disable iff (rst)
		irqLow |-> $past(!rxPrio_q))
		else $error("low request with high priority");
	chk_irq_periph: assert property (@(posedge clock) disable iff (rst)
		(irqHigh || irqLow) |-> $past(irqCtl_q[B_PERIPH_IE] && full_q))
		else $error("request without peripheral enable or character");
	chk_rd_idle: assert property (@(posedge clock) disable iff (rst)
		!regRd |=> regRdData == 8'h00)
		else $error("read data outside the read cycle");
endmodule

// ===== hdl/aur_pkg.sv
// holds the register map, field positions and timing constants of the receiver
// assumes a plain address/strobe register port and one 50 MHz clock
package aur_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] OFF_RX_STATUS = 3'h0;
	localparam logic [2:0] OFF_RX_DATA   = 3'h1;
	localparam logic [2:0] OFF_TX_STATUS = 3'h2;
	localparam logic [2:0] OFF_BAUD_CTL  = 3'h3;
	localparam logic [2:0] OFF_DIV_HIGH  = 3'h4;
	localparam logic [2:0] OFF_DIV_LOW   = 3'h5;
	localparam logic [2:0] OFF_IRQ_CTL   = 3'h6;
	localparam logic [2:0] OFF_IRQ_FLAG  = 3'h7;
	// ----------------------------------------------------------------
	// receive status/control fields
	// ----------------------------------------------------------------
	localparam int B_PORT_EN   = 7;
	localparam int B_NINTH_EN  = 6;
	localparam int B_CONT_EN   = 4;
	localparam int B_ADDR_EN   = 3;
	localparam int B_FRAME_ERR = 2;
	localparam int B_OVERRUN   = 1;
	localparam int B_NINTH_BIT = 0;
	// transmit status/control and baud control fields
	localparam int B_SYNC_SEL  = 4;
	localparam int B_HIGH_SPD  = 2;
	localparam int B_WIDE_DIV  = 3;
	// interrupt control fields; flag register holds flag/enable/priority
	localparam int B_GLOBAL_IE = 7;
	localparam int B_PERIPH_IE = 6;
	localparam int B_RX_FLAG   = 0;
	localparam int B_RX_IE     = 1;
	localparam int B_RX_PRIO   = 2;
	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_REG      = 8'h00;
	localparam int         OVERSAMPLE   = 16;
	localparam int         SAMPLE_POINT = 7;
	localparam int         DATA_BITS    = 9;
endpackage

// ===== hdl/aur_baud_gen.sv
// baud generator: one tick at 16x the bit rate for the recovery stage
// assumes divisor and select bits are stable while reception runs
`timescale 1ns/1ps
module aur_baud_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             highSpeed,
	input  wire logic             wideDiv,
	output logic                  tick
);
	import aur_pkg::*;

	logic [DIV_W-1:0] count_q;
	logic [1:0]       pre_q;
	logic             slow;
	logic             wrap;

	// slow path needs 64x prescale, folded down to 16x by a 4:1 stage
	assign slow = !highSpeed && !wideDiv;
	assign wrap = (count_q == '0);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else if (!run || wrap) begin
			count_q <= wideDiv ? divisor : DIV_W'(divisor[7:0]);
		end else begin
			count_q <= count_q - 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
		end else if (!run) begin
			pre_q <= '0;
		end else if (wrap) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	always_comb begin
		tick = run && wrap && (!slow || pre_q == 2'h3);
	end
endmodule

// ===== hdl/aur_recovery.sv
// data recovery: oversamples the line and yields one sampled bit per bit time
// assumes the line input is synchronous to clock
`timescale 1ns/1ps
module aur_recovery (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic tick,
	input  wire logic lineIn,
	output logic      startSeen,
	output logic      bitStrobe,
	output logic      bitValue
);
	import aur_pkg::*;

	logic [3:0] phase_q;
	logic       busy_q;
	logic       line_q;
	logic [2:0] vote_q;
	logic       mid;

	assign mid = tick && busy_q && phase_q == 4'(SAMPLE_POINT);

	// falling edge starts the bit clock; the start bit itself is checked
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			line_q <= 1'b1;
		end else begin
			line_q <= lineIn;
		end
	end

	assign startSeen = run && !busy_q && line_q && !lineIn;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_q  <= 1'b0;
			phase_q <= '0;
		end else if (!run) begin
			busy_q  <= 1'b0;
			phase_q <= '0;
		end else if (startSeen) begin
			busy_q  <= 1'b1;
			phase_q <= '0;
		end else if (tick && busy_q) begin
			phase_q <= phase_q + 1'b1;
		end
	end

	// three samples around mid-bit; majority vote rejects a glitch
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vote_q <= 3'h7;
		end else if (tick && busy_q) begin
			vote_q <= {vote_q[1:0], lineIn};
		end
	end

	assign bitStrobe = mid;
	assign bitValue  = (vote_q[0] & vote_q[1]) | (vote_q[1] & lineIn)
		| (vote_q[0] & lineIn);
endmodule

// ===== bench/aur_tx_model.sv
// remote serial transmitter that faces the receiver's line input
// assumes the bench calls send from one process; the line idles high
`timescale 1ns/1ps
module aur_tx_model (
	input  wire logic clock,
	output logic      line
);
	// ----------------------------------------------------------------
	// frame generator
	// ----------------------------------------------------------------
	initial line = 1'b1;

	task automatic send(
		input logic [8:0] data,
		input int         nBits,
		input int         bitClk,
		input logic       stopBit
	);
		int i;
		for (i = 0; i < nBits + 2; i++) begin
			@(posedge clock);
			if (i == 0) begin
				line <= 1'b0;
			end else if (i <= nBits) begin
				line <= data[i-1];
			end else begin
				line <= stopBit;
			end
			repeat (bitClk - 1) @(posedge clock);
		end
		// one idle bit so a following frame still opens with a falling edge
		@(posedge clock);
		line <= 1'b1;
		repeat (bitClk - 1) @(posedge clock);
	endtask
endmodule

// ===== bench/tb_aur_receiver.sv
// self-checking bench for the serial receiver with address detect
// assumes the aur_pkg register map and a transmitter model on the line
`timescale 1ns/1ps
module tb_aur_receiver;
	import aur_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int BIT_CLK = 32; // divisor 1, high speed: two clocks a tick
	localparam int LIMIT   = 30000;
	logic       clock;
	logic       rst;
	logic       serialInPin;
	logic [2:0] regAddr;
	logic [7:0] regWrData;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdData;
	logic       irqHigh;
	logic       irqLow;
	logic [7:0] rv;
	int         n_fail;
	int         n_checks;
	int         cyc = 0;

	aur_receiver u_aur_receiver (
		.clock       (clock),
		.rst         (rst),
		.serialInPin (serialInPin),
		.regAddr     (regAddr),
		.regWrData   (regWrData),
		.regWr       (regWr),
		.regRd       (regRd),
		.regRdData   (regRdData),
		.irqHigh     (irqHigh),
		.irqLow      (irqLow)
	);
	aur_tx_model u_aur_tx_model (
		.clock (clock),
		.line  (serialInPin)
	);

	// ----------------------------------------------------------------
	// clock, hang guard and closing report
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			$display("BAD %0t run did not finish in time", $time);
			final_report;
		end
	end

	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask

	task automatic expect_reg(input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e, input string what);
		rd(a, rv);
		check(rv & m, e, what);
	endtask

	task automatic check_irq(input logic [7:0] e, input string what);
		repeat (2) @(posedge clock);
		#1;
		check({6'h00, irqHigh, irqLow}, e, what);
	endtask

	// reception is switched off while the rate is changed
	task automatic setup(input logic [7:0] rx, tx, baud, lo);
		wr(OFF_RX_STATUS, 8'h00);
		wr(OFF_TX_STATUS, tx);
		wr(OFF_BAUD_CTL, baud);
		wr(OFF_DIV_HIGH, 8'h00);
		wr(OFF_DIV_LOW, lo);
		wr(OFF_RX_STATUS, rx);
	endtask

	task automatic tx(input logic [8:0] d, input int n, input logic stopBit);
		u_aur_tx_model.send(d, n, BIT_CLK, stopBit);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		int a;
		for (a = 0; a < 8; a++) begin
			expect_reg(3'(a), 8'hff, RST_REG, "reset value");
		end
		wr(OFF_RX_DATA, 8'h5a);
		expect_reg(OFF_RX_DATA, 8'hff, 8'h00, "data write ignored");
		wr(OFF_DIV_LOW, 8'h3c);
		expect_reg(OFF_DIV_LOW, 8'hff, 8'h3c, "divisor low");
		wr(OFF_IRQ_FLAG, 8'h01);
		expect_reg(OFF_IRQ_FLAG, 8'hff, 8'h00, "flag read only");
		$display("test regs done");
	endtask

	task automatic t_basic;
		setup(8'h90, 8'h04, 8'h00, 8'h01);
		wr(OFF_IRQ_FLAG, 8'h06);
		wr(OFF_IRQ_CTL, 8'h00);
		tx(9'h0a5, 8, 1'b1);
		expect_reg(OFF_IRQ_FLAG, 8'h01, 8'h01, "flag set");
		check_irq(8'h00, "request without globals");
		wr(OFF_IRQ_CTL, 8'hc0);
		check_irq(8'h02, "high priority request");
		expect_reg(OFF_RX_STATUS, 8'hff, 8'h90, "status clean");
		expect_reg(OFF_RX_DATA, 8'hff, 8'ha5, "data");
		expect_reg(OFF_IRQ_FLAG, 8'h01, 8'h00, "flag after read");
		check_irq(8'h00, "request drops");
		wr(OFF_IRQ_FLAG, 8'h02);
		tx(9'h03c, 8, 1'b1);
		check_irq(8'h01, "low priority request");
		wr(OFF_IRQ_FLAG, 8'h04);
		check_irq(8'h00, "request needs enable");
		expect_reg(OFF_RX_DATA, 8'hff, 8'h3c, "second data");
		wr(OFF_IRQ_CTL, 8'h00);
		$display("test basic done");
	endtask

	task automatic t_ninth;
		setup(8'hd0, 8'h04, 8'h00, 8'h01);
		tx(9'h13c, 9, 1'b1);
		expect_reg(OFF_RX_STATUS, 8'hff, 8'hd1, "ninth bit one");
		expect_reg(OFF_RX_DATA, 8'hff, 8'h3c, "ninth mode data");
		tx(9'h0c3, 9, 1'b1);
		expect_reg(OFF_RX_STATUS, 8'hff, 8'hd0, "ninth bit zero");
		expect_reg(OFF_RX_DATA, 8'hff, 8'hc3, "ninth mode data");
		$display("test ninth done");
	endtask

	task automatic t_addr;
		setup(8'hd8, 8'h04, 8'h00, 8'h01);
		tx(9'h011, 9, 1'b1);
		expect_reg(OFF_IRQ_FLAG, 8'h01, 8'h00, "data dropped");
		tx(9'h122, 9, 1'b1);
		expect_reg(OFF_IRQ_FLAG, 8'h01, 8'h01, "address kept");
		expect_reg(OFF_RX_DATA, 8'hff, 8'h22, "address byte");
		wr(OFF_RX_STATUS, 8'hd0);
		tx(9'h033, 9, 1'b1);
		expect_reg(OFF_IRQ_FLAG, 8'h01, 8'h01, "data kept");
		expect_reg(OFF_RX_DATA, 8'hff, 8'h33, "data byte");
		$display("test address done");
	endtask

	task automatic t_err;
		setup(8'h90, 8'h04, 8'h00, 8'h01);
		tx(9'h055, 8, 1'b0);
		expect_reg(OFF_RX_STATUS, 8'hff, 8'h94, "framing error");
		expect_reg(OFF_RX_DATA, 8'hff, 8'h55, "data, bad stop");
		tx(9'h0a1, 8, 1'b1);
		tx(9'h0b2, 8, 1'b1);
		expect_reg(OFF_RX_STATUS, 8'hff, 8'h92, "overrun");
		expect_reg(OFF_RX_DATA, 8'hff, 8'ha1, "first char kept");
		wr(OFF_RX_STATUS, 8'h80);
		expect_reg(OFF_RX_STATUS, 8'hff, 8'h80, "errors cleared");
		$display("test errors done");
	endtask

	task automatic t_off;
		logic [7:0] rxs [3] = '{8'h80, 8'h10, 8'h90};
		logic [7:0] txs [3] = '{8'h04, 8'h04, 8'h14};
		int i;
		for (i = 0; i < 3; i++) begin
			setup(rxs[i], txs[i], 8'h00, 8'h01);
			tx(9'h066, 8, 1'b1);
			expect_reg(OFF_IRQ_FLAG, 8'h01, 8'h00, "idle when off");
		end
		$display("test disabled done");
	endtask

	task automatic t_baud;
		logic [7:0] txs [3] = '{8'h00, 8'h00, 8'h04};
		logic [7:0] bds [3] = '{8'h00, 8'h08, 8'h08};
		logic [7:0] los [3] = '{8'h00, 8'h01, 8'h00};
		int         clk [3] = '{64, 32, 16};
		int         i;
		for (i = 0; i < 3; i++) begin
			setup(8'h90, txs[i], bds[i], los[i]);
			u_aur_tx_model.send(9'h081, 8, clk[i], 1'b1);
			expect_reg(OFF_RX_DATA, 8'hff, 8'h81, "rate");
		end
		$display("test baud done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_basic;
		t_ninth;
		t_addr;
		t_err;
		t_off;
		t_baud;
		final_report;
	end
endmodule
